// ---- core/rasi_pkg.sv ----
// Shared constants for the receive alarm status and interrupt block.
// Assumes an 8-bit register port and one 50 MHz system clock.
`default_nettype none

package rasi_pkg;

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_VIOL_CNT = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_FRAMING_BIT_ERROR_CNT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 3'h4;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ALL_ONES_BYTE = 8'hff;
	localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

	// ---------------------------------------------------------------
	// Status and mask bit positions
	// ---------------------------------------------------------------
	localparam int BIT_VIOL_SAT = 7;
	localparam int BIT_ERR_SAT = 6;
	localparam int BIT_REMOTE = 5;
	localparam int BIT_CARRIER = 4;
	localparam int BIT_FRAMING_BIT_ERROR = 3;
	localparam int BIT_SUBST = 2;
	localparam int BIT_ALL_ONES = 1;
	localparam int BIT_SYNC_LOSS = 0;

	// ---------------------------------------------------------------
	// Configuration bit positions
	// ---------------------------------------------------------------
	localparam int CFG_WINDOW_FIVE = 0;
	localparam int CFG_SYNC_CRITERIA = 1;
	localparam int CFG_ESF_MODE = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Counter fields
	// ---------------------------------------------------------------
	localparam int VIOL_W = 8;
	localparam int NIB_W = 4;
	localparam int OOF_LSB = 4;
	localparam int ESF_LSB = 0;

	// ---------------------------------------------------------------
	// Detector figures
	// ---------------------------------------------------------------
	localparam int CL_ZEROS = 32;
	localparam int CL_W = 6;
	localparam int AO_LIMIT = 3;
	localparam int AO_W = 8;
	localparam int OOF_ERRS = 2;
	localparam int WIN_SHORT = 4;
	localparam int WIN_LONG = 5;
	localparam int FRAMING_BIT_ERROR_HOLD = 2;

endpackage : rasi_pkg

`default_nettype wire

// ---- core/rasi_sat_counter.sv ----
// Presettable saturating up counter for alarm event counting.
// Assumes preset and increment strobes are one clock wide.
`default_nettype none

module rasi_sat_counter #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic inc,
	output logic [W-1:0] count_q,
	output logic sat_event
);

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	localparam logic [W-1:0] MAXV = '1;
	localparam logic [W-1:0] ONE = W'(1);

	// Each event past saturation is reported, not only the first
	assign sat_event = inc && !load && (count_q == MAXV);

	// A preset wins over a coincident event so the threshold is exact
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_value;
		end else if (inc && (count_q != MAXV)) begin
			count_q <= count_q + ONE;
		end
	end

endmodule : rasi_sat_counter

`default_nettype wire

// ---- core/rasi_alarm_core.sv ----
// Receive alarm status, interrupt masking and alarm event counting.
// Assumes the line-side strobes are synchronous one-cycle pulses per bit.
//
// Local design decisions: the address map and strobed register access.
`default_nettype none
// Notes on behaviour
// - Each alarm drives its own output pin and a latched status bit.
// - Interrupts come from real-time alarms and from counter saturation.
// - Every status bit has a mask bit; a zero mask bit blocks it.
// - Clearing a mask bit drops that source's interrupt at once.
// - A direct status read clears real-time bits unless still present.
// - A direct status read leaves both saturation bits set.
// - Saturation bit clears only on a counter preset that is not all ones.
// - A burst read of status clears nothing.
// - All three counters are host presettable and count up from there.
// - Each event after saturation sets the saturation bit again.
// - Counter reads never disturb counting.
// - Out of frame when two framing bits err within four or five.
// - Terminal bits tested in superframe and in extended mode alike.
// - Out of frame events count in the upper error counter nibble.
// - Extended mode ORs out of frame with CRC failure into own counter.
// - Superframe mode counts signaling errors too when criteria bit set.
// - Status bit two sets on a substitution code word.
// - Mask bit seven at one enables the violation saturation interrupt.
// - Sync loss status latches the sync_loss_in input, not the registered pin.

module rasi_alarm_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic [rasi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rasi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_burst,
	output logic [rasi_pkg::DATA_W-1:0] reg_rdata,
	input wire logic bit_valid,
	input wire logic bit_one,
	input wire logic bit_is_fbit,
	input wire logic fbit_terminal,
	input wire logic fbit_error,
	input wire logic frame_end,
	input wire logic crc_error,
	input wire logic violation_seen,
	input wire logic code_word_seen,
	input wire logic remote_alarm_in,
	input wire logic sync_loss_in,
	output logic remote_alarm_detected,
	output logic carrier_loss_detected,
	output logic framing_bit_error,
	output logic substitution_code_detected,
	output logic all_ones_alarm_detected,
	output logic sync_loss,
	output logic out_of_frame_event,
	output logic irq
);

	// ---------------------------------------------------------------
	// Register port decode
	// ---------------------------------------------------------------
	logic wr_mask;
	logic wr_viol;
	logic wr_framing_bit_error;
	logic wr_cfg;
	logic rd_status_direct;
	logic [rasi_pkg::DATA_W-1:0] mask_q;
	logic [rasi_pkg::DATA_W-1:0] mask_d;
	logic [2:0] cfg_q;
	logic window_five;
	logic sync_criteria_select;
	logic extended_superframe_mode;

	assign wr_mask = reg_wr && (reg_addr == rasi_pkg::ADDR_MASK);
	assign wr_viol = reg_wr && (reg_addr == rasi_pkg::ADDR_VIOL_CNT);
	assign wr_framing_bit_error = reg_wr && (reg_addr == rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT);
	assign wr_cfg = reg_wr && (reg_addr == rasi_pkg::ADDR_CONFIG);
	// Burst reads carry reg_burst high and never count as direct
	assign rd_status_direct = reg_rd && !reg_burst
		&& (reg_addr == rasi_pkg::ADDR_STATUS);
	assign window_five = cfg_q[rasi_pkg::CFG_WINDOW_FIVE];
	assign sync_criteria_select = cfg_q[rasi_pkg::CFG_SYNC_CRITERIA];
	assign extended_superframe_mode = cfg_q[rasi_pkg::CFG_ESF_MODE];
	assign mask_d = wr_mask ? reg_wdata : mask_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_q <= rasi_pkg::MASK_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= rasi_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= reg_wdata[2:0];
		end
	end

	// ---------------------------------------------------------------
	// Level alarm pins
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remote_alarm_detected <= 1'b0;
			sync_loss <= 1'b0;
		end else begin
			remote_alarm_detected <= remote_alarm_in;
			sync_loss <= sync_loss_in;
		end
	end

	// ---------------------------------------------------------------
	// Carrier loss detector
	// ---------------------------------------------------------------
	logic [rasi_pkg::CL_W-1:0] zero_run_q;
	logic carrier_set;

	assign carrier_set = bit_valid && !bit_one
		&& (zero_run_q == rasi_pkg::CL_W'(rasi_pkg::CL_ZEROS - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zero_run_q <= '0;
			carrier_loss_detected <= 1'b0;
		end else if (bit_valid) begin
			if (bit_one) begin
				zero_run_q <= '0;
				carrier_loss_detected <= 1'b0;
			end else begin
				if (zero_run_q != rasi_pkg::CL_W'(rasi_pkg::CL_ZEROS)) begin
					zero_run_q <= zero_run_q + rasi_pkg::CL_W'(1);
				end
				if (carrier_set) begin
					carrier_loss_detected <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// All-ones alarm detector
	// ---------------------------------------------------------------
	// Zeros are counted only outside framing bit positions
	logic [rasi_pkg::AO_W-1:0] frame_zeros_q;
	logic [rasi_pkg::AO_W-1:0] prev_zeros_q;
	logic [rasi_pkg::AO_W:0] pair_zeros;
	logic [rasi_pkg::AO_W-1:0] frame_zeros_now;
	logic zero_payload;

	assign zero_payload = bit_valid && !bit_one && !bit_is_fbit;
	assign frame_zeros_now = (zero_payload
		&& frame_zeros_q != rasi_pkg::ALL_ONES_BYTE)
		? frame_zeros_q + rasi_pkg::AO_W'(1) : frame_zeros_q;
	assign pair_zeros = {1'b0, prev_zeros_q} + {1'b0, frame_zeros_now};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_zeros_q <= '0;
			prev_zeros_q <= rasi_pkg::ALL_ONES_BYTE;
			all_ones_alarm_detected <= 1'b0;
		end else if (frame_end) begin
			frame_zeros_q <= '0;
			prev_zeros_q <= frame_zeros_now;
			all_ones_alarm_detected <=
				(pair_zeros < (rasi_pkg::AO_W + 1)'(rasi_pkg::AO_LIMIT));
		end else begin
			frame_zeros_q <= frame_zeros_now;
		end
	end

	// ---------------------------------------------------------------
	// Framing bit error and out of frame detection
	// ---------------------------------------------------------------
	logic tested_fbit;
	logic tested_err;
	logic signal_err;
	logic [rasi_pkg::WIN_LONG-1:0] err_hist_q;
	logic [rasi_pkg::WIN_LONG-1:0] err_hist_now;
	logic [2:0] win_errs;
	logic oof_now;
	logic [1:0] framing_bit_error_hold_q;

	// Terminal bits in both superframe and extended superframe modes
	assign tested_fbit = bit_valid && bit_is_fbit && fbit_terminal;
	assign tested_err = tested_fbit && fbit_error;
	assign signal_err = bit_valid && bit_is_fbit && !fbit_terminal && fbit_error;
	assign err_hist_now = {err_hist_q[rasi_pkg::WIN_LONG-2:0], fbit_error};

	always_comb begin
		win_errs = 3'(err_hist_now[0]) + 3'(err_hist_now[1])
			+ 3'(err_hist_now[2]) + 3'(err_hist_now[3]);
		if (window_five) begin
			win_errs = win_errs + 3'(err_hist_now[rasi_pkg::WIN_LONG-1]);
		end
	end

	assign oof_now = tested_fbit && fbit_error
		&& (win_errs >= 3'(rasi_pkg::OOF_ERRS));

	// History restarts after a declaration so one burst gives one event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_hist_q <= '0;
		end else if (oof_now) begin
			err_hist_q <= '0;
		end else if (tested_fbit) begin
			err_hist_q <= err_hist_now;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_of_frame_event <= 1'b0;
		end else begin
			out_of_frame_event <= oof_now;
		end
	end

	// Error pin stays high for two bit periods
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			framing_bit_error_hold_q <= '0;
			framing_bit_error <= 1'b0;
		end else if (tested_err) begin
			framing_bit_error_hold_q <= 2'(rasi_pkg::FRAMING_BIT_ERROR_HOLD);
			framing_bit_error <= 1'b1;
		end else if (bit_valid && framing_bit_error_hold_q != 2'h0) begin
			framing_bit_error_hold_q <= framing_bit_error_hold_q - 2'h1;
			framing_bit_error <= (framing_bit_error_hold_q != 2'h1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			substitution_code_detected <= 1'b0;
		end else begin
			substitution_code_detected <= code_word_seen;
		end
	end

	// ---------------------------------------------------------------
	// Alarm event counters
	// ---------------------------------------------------------------
	logic [rasi_pkg::VIOL_W-1:0] viol_cnt;
	logic [rasi_pkg::NIB_W-1:0] oof_cnt;
	logic [rasi_pkg::NIB_W-1:0] esf_cnt;
	logic viol_sat;
	logic oof_sat;
	logic esf_sat;
	logic count_gate;
	logic esf_inc;

	// Frame error counts halt while a resync is under way
	assign count_gate = !sync_loss_in;
	always_comb begin
		if (extended_superframe_mode) begin
			esf_inc = count_gate && (oof_now || crc_error);
		end else begin
			esf_inc = count_gate && (tested_err
				|| (sync_criteria_select && signal_err));
		end
	end

	rasi_sat_counter #(
		.W(rasi_pkg::VIOL_W)
	) u_viol_cnt (
		.clk(clk),
		.rst(rst),
		.load(wr_viol),
		.load_value(reg_wdata),
		.inc(violation_seen),
		.count_q(viol_cnt),
		.sat_event(viol_sat)
	);

	rasi_sat_counter #(
		.W(rasi_pkg::NIB_W)
	) u_oof_cnt (
		.clk(clk),
		.rst(rst),
		.load(wr_framing_bit_error),
		.load_value(reg_wdata[rasi_pkg::OOF_LSB +: rasi_pkg::NIB_W]),
		.inc(count_gate && oof_now),
		.count_q(oof_cnt),
		.sat_event(oof_sat)
	);

	rasi_sat_counter #(
		.W(rasi_pkg::NIB_W)
	) u_esf_cnt (
		.clk(clk),
		.rst(rst),
		.load(wr_framing_bit_error),
		.load_value(reg_wdata[rasi_pkg::ESF_LSB +: rasi_pkg::NIB_W]),
		.inc(esf_inc),
		.count_q(esf_cnt),
		.sat_event(esf_sat)
	);

	// ---------------------------------------------------------------
	// Status register
	// ---------------------------------------------------------------
	logic [rasi_pkg::DATA_W-1:0] set_vec;
	logic [rasi_pkg::DATA_W-1:0] clr_vec;
	logic [rasi_pkg::DATA_W-1:0] status_q;
	logic [rasi_pkg::DATA_W-1:0] status_d;
	logic preset_clear;

	// A preset of all ones keeps the saturation bit standing
	assign preset_clear = reg_wdata != rasi_pkg::ALL_ONES_BYTE;

	always_comb begin
		set_vec = rasi_pkg::ZERO_BYTE;
		set_vec[rasi_pkg::BIT_VIOL_SAT] = viol_sat;
		set_vec[rasi_pkg::BIT_ERR_SAT] = oof_sat || esf_sat;
		set_vec[rasi_pkg::BIT_REMOTE] = remote_alarm_in;
		set_vec[rasi_pkg::BIT_CARRIER] = carrier_set || carrier_loss_detected;
		set_vec[rasi_pkg::BIT_FRAMING_BIT_ERROR] = tested_err;
		set_vec[rasi_pkg::BIT_SUBST] = code_word_seen;
		set_vec[rasi_pkg::BIT_ALL_ONES] = all_ones_alarm_detected;
		set_vec[rasi_pkg::BIT_SYNC_LOSS] = sync_loss_in;
	end

	always_comb begin
		clr_vec = rasi_pkg::ZERO_BYTE;
		clr_vec[rasi_pkg::BIT_VIOL_SAT] = wr_viol && preset_clear;
		clr_vec[rasi_pkg::BIT_ERR_SAT] = wr_framing_bit_error && preset_clear;
		clr_vec[rasi_pkg::BIT_REMOTE] = rd_status_direct;
		clr_vec[rasi_pkg::BIT_CARRIER] = rd_status_direct;
		clr_vec[rasi_pkg::BIT_FRAMING_BIT_ERROR] = rd_status_direct;
		clr_vec[rasi_pkg::BIT_SUBST] = rd_status_direct;
		clr_vec[rasi_pkg::BIT_ALL_ONES] = rd_status_direct;
		clr_vec[rasi_pkg::BIT_SYNC_LOSS] = rd_status_direct;
	end

	// Set wins over clear, so a present condition survives a read
	for (genvar i = 0; i < rasi_pkg::DATA_W; i++) begin : g_status
		assign status_d[i] = set_vec[i] || (status_q[i] && !clr_vec[i]);
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				status_q[i] <= 1'b0;
			end else begin
				status_q[i] <= status_d[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------
	// Uses next-state mask so a cleared bit drops the line on the next edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_d & mask_d);
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Counter reads have no side effect on counting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= rasi_pkg::ZERO_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				rasi_pkg::ADDR_STATUS: reg_rdata <= status_q;
				rasi_pkg::ADDR_MASK: reg_rdata <= mask_q;
				rasi_pkg::ADDR_VIOL_CNT: reg_rdata <= viol_cnt;
				rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT: reg_rdata <= {oof_cnt, esf_cnt};
				rasi_pkg::ADDR_CONFIG: reg_rdata <= {5'h00, cfg_q};
				default: reg_rdata <= rasi_pkg::ZERO_BYTE;
			endcase
		end else begin
			reg_rdata <= rasi_pkg::ZERO_BYTE;
		end
	end

endmodule : rasi_alarm_core

`default_nettype wire

// ---- tb/rasi_alarm_chk_sva.sv ----
// Checker for the receive alarm core, bound to its ports.
// Assumes one clock domain and the registered outputs of the core.
`default_nettype none

module rasi_alarm_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [rasi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rasi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_burst,
	input wire logic bit_valid,
	input wire logic bit_is_fbit,
	input wire logic fbit_terminal,
	input wire logic fbit_error,
	input wire logic code_word_seen,
	input wire logic remote_alarm_in,
	input wire logic sync_loss_in,
	input wire logic bit_one,
	input wire logic remote_alarm_detected,
	input wire logic carrier_loss_detected,
	input wire logic framing_bit_error,
	input wire logic substitution_code_detected,
	input wire logic sync_loss,
	input wire logic out_of_frame_event,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// Properties
	// ----
	property p_mask_off;
		reg_wr && reg_addr == rasi_pkg::ADDR_MASK && reg_wdata == 8'h00 |=> !irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq kept after mask clear");
	property p_burst;
		irq && reg_rd && reg_burst |=> irq;
	endproperty
	a_burst: assert property (p_burst) else $error("burst read dropped irq");
	property p_remote;
		$rose(remote_alarm_in) |=> remote_alarm_detected;
	endproperty
	a_remote: assert property (p_remote) else $error("remote alarm pin late");
	property p_sync;
		sync_loss_in |=> sync_loss;
	endproperty
	a_sync: assert property (p_sync) else $error("sync loss pin late");
	property p_subst;
		code_word_seen |=> substitution_code_detected;
	endproperty
	a_subst: assert property (p_subst) else $error("code word not flagged");
	property p_cl_off;
		carrier_loss_detected && bit_valid && bit_one |=> !carrier_loss_detected;
	endproperty
	a_cl_off: assert property (p_cl_off) else $error("carrier loss kept after a one");
	// Only tested framing bits may start the error flag
	property p_framing_bit_error;
		$rose(framing_bit_error) |-> $past(bit_valid) && $past(bit_is_fbit)
			&& $past(fbit_terminal) && $past(fbit_error);
	endproperty
	a_framing_bit_error: assert property (p_framing_bit_error) else $error("frame error without tested bit");
	property p_oof;
		out_of_frame_event |-> $past(bit_valid) && $past(bit_is_fbit)
			&& $past(fbit_terminal) && $past(fbit_error);
	endproperty
	a_oof: assert property (p_oof) else $error("out of frame without erroring bit");
endmodule : rasi_alarm_chk

bind rasi_alarm_core rasi_alarm_chk rasi_alarm_chk_i (.clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_burst, .bit_valid, .bit_is_fbit, .fbit_terminal, .fbit_error,
	.code_word_seen, .remote_alarm_in, .sync_loss_in, .bit_one, .remote_alarm_detected,
	.carrier_loss_detected, .framing_bit_error, .substitution_code_detected, .sync_loss,
	.out_of_frame_event, .irq);

`default_nettype wire

// ---- tb/rasi_host_model.sv ----
// Host processor model driving the register port of the alarm core.
// Assumes read data stand only in the cycle after the read strobe.
`default_nettype none

module rasi_host_model (
	input wire logic clk,
	output logic [rasi_pkg::ADDR_W-1:0] reg_addr,
	output logic [rasi_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_burst,
	input wire logic [rasi_pkg::DATA_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 3'h7;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_burst = 1'b0;
	end
	// Released lines show the inverse, so stale values never look valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic b, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_burst <= b;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_burst <= ~b;
		#1 d = reg_rdata;
	endtask : rd
endmodule : rasi_host_model

`default_nettype wire

// ---- tb/rasi_alarm_core_tb_top.sv ----
// Self-checking bench for the receive alarm core.
// Assumes the host model for register traffic; line strobes come from here.
`default_nettype none

module rasi_alarm_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_burst;
	logic bit_valid = 1'b0, bit_one = 1'b0, bit_is_fbit = 1'b0, fbit_terminal = 1'b0;
	logic fbit_error = 1'b0, frame_end = 1'b0, crc_error = 1'b0, violation_seen = 1'b0;
	logic code_word_seen = 1'b0, remote_alarm_in = 1'b0, sync_loss_in = 1'b0;
	logic remote_alarm_detected, carrier_loss_detected, framing_bit_error;
	logic substitution_code_detected, all_ones_alarm_detected, sync_loss;
	logic out_of_frame_event, irq;
	logic [7:0] oof_n = 8'h00;
	int mismatches = 0;
	int total_checks = 0;
	always #10 clk = ~clk;
	always @(posedge clk) if (out_of_frame_event === 1'b1) oof_n <= oof_n + 8'h01;
	rasi_alarm_core rasi_alarm_core_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_burst, .reg_rdata, .bit_valid, .bit_one, .bit_is_fbit, .fbit_terminal,
		.fbit_error, .frame_end, .crc_error, .violation_seen, .code_word_seen,
		.remote_alarm_in, .sync_loss_in, .remote_alarm_detected, .carrier_loss_detected,
		.framing_bit_error, .substitution_code_detected, .all_ones_alarm_detected,
		.sync_loss, .out_of_frame_event, .irq);
	rasi_host_model rasi_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_burst, .reg_rdata);
	// ----
	// Helpers
	// ----
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %0t: got %h want %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %0t: flag %b want %b", $time, g, e);
		end
	endtask : chk1
	task automatic rdc(input logic [2:0] a, input logic b, input logic [7:0] e);
		logic [7:0] d;
		rasi_host_model_i.rd(a, b, d);
		chk8(d, e);
	endtask : rdc
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		rasi_host_model_i.wr(a, d);
	endtask : wr
	// Levels are given time to land, irq is registered
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// One received bit: {one, framing position, tested, errored}
	task automatic lbit(input logic [3:0] v);
		@(posedge clk);
		bit_valid <= 1'b1;
		{bit_one, bit_is_fbit, fbit_terminal, fbit_error} <= v;
		@(posedge clk);
		bit_valid <= 1'b0;
		{bit_one, bit_is_fbit, fbit_terminal, fbit_error} <= 4'h0;
	endtask : lbit
	// One-cycle strobes: {crc, violation, code word}
	task automatic pls(input logic [2:0] v);
		@(posedge clk);
		{crc_error, violation_seen, code_word_seen} <= v;
		@(posedge clk);
		{crc_error, violation_seen, code_word_seen} <= 3'h0;
	endtask : pls
	task automatic fend;
		@(posedge clk);
		frame_end <= 1'b1;
		@(posedge clk);
		frame_end <= 1'b0;
	endtask : fend
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		rdc(rasi_pkg::ADDR_MASK, 1'b0, 8'h00);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h00);
		rdc(3'h5, 1'b0, 8'h00);
		chk1(irq, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_viol;
		wr(rasi_pkg::ADDR_MASK, 8'h80);
		wr(rasi_pkg::ADDR_VIOL_CNT, 8'hfe);
		pls(3'h2);
		settle;
		chk1(irq, 1'b0);
		rdc(rasi_pkg::ADDR_VIOL_CNT, 1'b0, 8'hff);
		pls(3'h2);
		settle;
		chk1(irq, 1'b1);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h80);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h80);
		wr(rasi_pkg::ADDR_VIOL_CNT, 8'hff);
		settle;
		chk1(irq, 1'b1);
		wr(rasi_pkg::ADDR_VIOL_CNT, 8'h00);
		settle;
		chk1(irq, 1'b0);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h00);
		$display("violation test done");
	endtask : t_viol
	task automatic t_rt;
		wr(rasi_pkg::ADDR_MASK, 8'h04);
		pls(3'h1);
		settle;
		chk1(irq, 1'b1);
		rdc(rasi_pkg::ADDR_STATUS, 1'b1, 8'h04);
		settle;
		chk1(irq, 1'b1);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h04);
		settle;
		chk1(irq, 1'b0);
		wr(rasi_pkg::ADDR_MASK, 8'h20);
		@(posedge clk);
		{remote_alarm_in, sync_loss_in} <= 2'h3;
		settle;
		chk1(irq, 1'b1);
		chk1(remote_alarm_detected, 1'b1);
		chk1(sync_loss, 1'b1);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h21);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h21);
		wr(rasi_pkg::ADDR_MASK, 8'h00);
		settle;
		chk1(irq, 1'b0);
		@(posedge clk);
		{remote_alarm_in, sync_loss_in} <= 2'h0;
		settle;
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h21);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h00);
		$display("real-time test done");
	endtask : t_rt
	task automatic t_oof;
		wr(rasi_pkg::ADDR_MASK, 8'h40);
		wr(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 8'hf0);
		wr(rasi_pkg::ADDR_CONFIG, 8'h00);
		repeat (2) lbit(4'hf);
		repeat (2) lbit(4'he);
		settle;
		chk8(oof_n, 8'h01);
		chk1(irq, 1'b1);
		rdc(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 1'b0, 8'hf2);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h48);
		wr(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 8'h00);
		settle;
		chk1(irq, 1'b0);
		for (int w = 0; w < 2; w++) begin
			wr(rasi_pkg::ADDR_CONFIG, 8'(w));
			repeat (4) lbit(4'he);
			lbit(4'hf);
			repeat (3) lbit(4'he);
			lbit(4'hf);
			settle;
			chk8(oof_n, 8'(1 + w));
		end
		repeat (2) lbit(4'he);
		rdc(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 1'b0, 8'h14);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h08);
		$display("out of frame test done");
	endtask : t_oof
	task automatic t_esf;
		wr(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 8'h00);
		for (int c = 0; c < 2; c++) begin
			wr(rasi_pkg::ADDR_CONFIG, 8'(c * 2));
			lbit(4'hd);
			rdc(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 1'b0, 8'(c));
		end
		wr(rasi_pkg::ADDR_CONFIG, 8'h04);
		pls(3'h4);
		rdc(rasi_pkg::ADDR_FRAMING_BIT_ERROR_CNT, 1'b0, 8'h02);
		$display("errored superframe test done");
	endtask : t_esf
	task automatic t_carrier;
		wr(rasi_pkg::ADDR_MASK, 8'h10);
		lbit(4'h8);
		repeat (31) lbit(4'h0);
		settle;
		chk1(carrier_loss_detected, 1'b0);
		lbit(4'h0);
		settle;
		chk1(carrier_loss_detected, 1'b1);
		chk1(irq, 1'b1);
		lbit(4'h8);
		settle;
		chk1(carrier_loss_detected, 1'b0);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h10);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h00);
		$display("carrier loss test done");
	endtask : t_carrier
	// A zero at a framing position must not count toward the all-ones total
	task automatic t_blue;
		wr(rasi_pkg::ADDR_MASK, 8'h02);
		repeat (2) fend;
		settle;
		chk1(all_ones_alarm_detected, 1'b0);
		repeat (2) lbit(4'h0);
		lbit(4'h4);
		fend;
		settle;
		chk1(all_ones_alarm_detected, 1'b1);
		chk1(irq, 1'b1);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h02);
		lbit(4'h0);
		fend;
		settle;
		chk1(all_ones_alarm_detected, 1'b0);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h02);
		rdc(rasi_pkg::ADDR_STATUS, 1'b0, 8'h00);
		$display("all-ones test done");
	endtask : t_blue
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_viol();
		t_rt();
		t_oof();
		t_esf();
		t_carrier();
		t_blue();
		finish_test();
	end
	// All tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		finish_test();
	end
endmodule : rasi_alarm_core_tb_top

`default_nettype wire
